// >>> hw/asfi_regs.vh
// Constants for the accumulator-store, flag and interrupt command block.
// Assumes a 32-bit APB register port and nine-byte command frames.
`ifndef ASFI_REGS_VH
`define ASFI_REGS_VH
`define ASFI_OP_AXSTORE  8'h22
`define ASFI_OP_GLSTORE  8'h23
`define ASFI_OP_CLE      8'h24
`define ASFI_OP_IRQON    8'h19
`define ASFI_OP_IRQOFF   8'h1A
`define ASFI_OP_SETVEC   8'h25
`define ASFI_OP_IRQRET   8'h26
`define ASFI_IRQ_GLOBAL  8'hFF
`define ASFI_BANK_USER   8'h02
`define ASFI_CLE_ALL     8'h00
`define ASFI_CLE_LAST    8'h05
`define ASFI_ST_OK       8'h64
`define ASFI_ST_CSUM     8'h01
`define ASFI_ST_BADCMD   8'h02
`define ASFI_FRAME_LAST  4'h8
`define ASFI_NFLAGS      5
`define ASFI_NIRQ        16
`define ASFI_IRQ_W       4
`define ASFI_PC_W        24
`define ASFI_A_CMD       8'h00
`define ASFI_A_REPLY     8'h04
`define ASFI_A_EVT       8'h08
`define ASFI_A_MASK      8'h0C
`define ASFI_A_STATE     8'h10
`define ASFI_A_IRQEN     8'h14
`define ASFI_EVT_DONE    0
`define ASFI_EVT_CSUM    1
`define ASFI_EVT_W       2
`define ASFI_ZERO32      32'h0000_0000
`endif

// >>> hw/asfi_cmd_exec.v
// Command execution for accumulator stores, error-flag clears and interrupt control.
// Assumes one clock, APB register access, and program-side inputs on the same clock.
// Contract
// - Opcode 34 stores accumulator to axis parameter.
// - Opcode 35 stores accumulator to global parameter.
// - Bank 2 of opcode 35 targets user variable.
// - Opcode 36 clears error flags by type.
// - Selector 0 all, 1 to 5 single flags.
// - Opcode 25 sets one interrupt enable.
// - Interrupt 255 on opcode 25 enables globally.
// - Opcode 26 clears one interrupt enable.
// - Interrupt 255 on opcode 26 disables globally.
// - Vector command stores handler entry address.
// - Later vector command overwrites earlier entry.
// - Interrupt return restores accumulator, X, flags, PC.
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "asfi_regs.vh"
`default_nettype none
module asfi_cmd_exec (
  // Clock and reset.
  input  wire        sys_clk,
  input  wire        rst_b,
  // APB slave.
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Instruction from the stored-program sequencer.
  input  wire        progValid,
  input  wire [7:0]  progOp,
  input  wire [7:0]  progType,
  input  wire [7:0]  progBank,
  input  wire [31:0] progValue,
  // Live processor state.
  input  wire [31:0] curAcc,
  input  wire [31:0] curX,
  input  wire [7:0]  curFlags,
  input  wire [23:0] curPc,
  // Interrupt entry from the sequencer and vector lookup.
  input  wire        irqEntry,
  input  wire [3:0]  vecIdx,
  output reg  [23:0] vecAddr,
  // Error flag sources.
  input  wire [4:0]  errSet,
  output reg  [4:0]  errFlags,
  // Parameter write strobes.
  output reg         axisParamWr,
  output reg         globalParamWr,
  output reg         userVarWr,
  output reg  [7:0]  paramNum,
  output reg  [7:0]  paramBank,
  output reg  [31:0] paramData,
  // Interrupt enables and context restore.
  output reg  [15:0] irqEnable,
  output reg         irqGlobalEn,
  output reg         ctxRestore,
  output reg  [31:0] rstAcc,
  output reg  [31:0] rstX,
  output reg  [7:0]  rstFlags,
  output reg  [23:0] rstPc,
  // Interrupt to the host CPU.
  output reg         irqOut
);

  // Error-clear selector to flag mask; out-of-range selectors clear nothing.
  function [4:0] cleMask;
    input [7:0] sel;
    begin
      if (sel == `ASFI_CLE_ALL) begin
        cleMask = 5'h1F;
      end else if (sel <= `ASFI_CLE_LAST) begin
        cleMask = 5'h01 << (sel - 8'h01);
      end else begin
        cleMask = 5'h00;
      end
    end
  endfunction

  // True for every opcode this block executes.
  function known;
    input [7:0] op;
    begin
      known = (op == `ASFI_OP_AXSTORE) || (op == `ASFI_OP_GLSTORE) || (op == `ASFI_OP_CLE) ||
              (op == `ASFI_OP_IRQON) || (op == `ASFI_OP_IRQOFF) || (op == `ASFI_OP_SETVEC) ||
              (op == `ASFI_OP_IRQRET);
    end
  endfunction

  // Frame buffer, reply state, vector table and saved context live in flip-flops.
  reg  [7:0]  frame_reg [0:8];
  reg  [3:0]  byteCnt_reg;
  reg  [7:0]  sum_reg;
  reg         dirPend_reg;
  reg  [7:0]  replyStat_reg;
  reg  [7:0]  replyOp_reg;
  reg  [`ASFI_EVT_W-1:0] evt_reg;
  reg  [`ASFI_EVT_W-1:0] mask_reg;
  reg  [23:0] vec_reg [0:15];
  reg  [31:0] svAcc_reg;
  reg  [31:0] svX_reg;
  reg  [7:0]  svFlags_reg;
  reg  [23:0] svPc_reg;
  // Decoded bus strobes and the instruction chosen for the executor.
  wire        apbWr;
  wire        apbRd;
  wire        byteWr;
  wire        frameEnd;
  wire        csumOk;
  wire        useProg;
  wire        execGo;
  wire [7:0]  exOp;
  wire [7:0]  exType;
  wire [7:0]  exBank;
  wire [31:0] exValue;
  reg  [`ASFI_EVT_W-1:0] evtSet;
  integer     i;

  // Accesses take effect in their first access cycle; the registered pready adds one wait state.
  assign apbWr    = psel && penable && !pready && pwrite;
  assign apbRd    = psel && penable && !pready && !pwrite;
  assign byteWr   = apbWr && (paddr == `ASFI_A_CMD);
  assign frameEnd = byteWr && (byteCnt_reg == `ASFI_FRAME_LAST);
  assign csumOk   = (sum_reg == pwdata[7:0]);

  // Program instructions win the executor; a direct command waits while progValid is high.
  assign useProg  = progValid;
  assign execGo   = progValid || dirPend_reg;
  assign exOp     = useProg ? progOp    : frame_reg[1];
  assign exType   = useProg ? progType  : frame_reg[2];
  assign exBank   = useProg ? progBank  : frame_reg[3];
  assign exValue  = useProg ? progValue : {frame_reg[4], frame_reg[5], frame_reg[6], frame_reg[7]};

  // Events raised this cycle.
  always @* begin
    evtSet = {`ASFI_EVT_W{1'b0}};
    evtSet[`ASFI_EVT_DONE] = dirPend_reg && !useProg;
    evtSet[`ASFI_EVT_CSUM] = frameEnd && !csumOk;
  end

  // APB handshake and read mux; a read of the event register clears it below.
  // Unmapped reads and writes to read-only words answer with an error and no effect.
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `ASFI_ZERO32;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata  <= `ASFI_ZERO32;
      if (apbRd) begin
        case (paddr)
          `ASFI_A_CMD:   prdata <= {28'h000_0000, byteCnt_reg};
          `ASFI_A_REPLY: prdata <= {16'h0000, replyOp_reg, replyStat_reg};
          `ASFI_A_EVT:   prdata <= {30'h0000_0000, evt_reg};
          `ASFI_A_MASK:  prdata <= {30'h0000_0000, mask_reg};
          `ASFI_A_STATE: prdata <= {23'h00_0000, dirPend_reg, 2'b00, irqGlobalEn, errFlags};
          `ASFI_A_IRQEN: prdata <= {16'h0000, irqEnable};
          default:       pslverr <= 1'b1;
        endcase
      end else if (apbWr) begin
        pslverr <= !((paddr == `ASFI_A_CMD) || (paddr == `ASFI_A_MASK));
      end
    end
  end

  // Frame assembly: bytes arrive low to high, checksum is the ninth byte.
  // The counter restarts on the ninth byte whether or not the sum matches.
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      byteCnt_reg <= 4'h0;
      sum_reg     <= 8'h00;
      for (i = 0; i < 9; i = i + 1) begin
        frame_reg[i] <= 8'h00;
      end
    end else if (byteWr) begin
      frame_reg[byteCnt_reg] <= pwdata[7:0];
      if (frameEnd) begin
        byteCnt_reg <= 4'h0;
        sum_reg     <= 8'h00;
      end else begin
        byteCnt_reg <= byteCnt_reg + 4'h1;
        sum_reg     <= sum_reg + pwdata[7:0];
      end
    end
  end

  // Direct command pending flag and the reply it produces.
  // A bad checksum never executes; it only updates the reply and the event.
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      dirPend_reg   <= 1'b0;
      replyStat_reg <= 8'h00;
      replyOp_reg   <= 8'h00;
    end else begin
      if (dirPend_reg && !useProg) begin
        dirPend_reg   <= 1'b0;
        replyOp_reg   <= frame_reg[1];
        replyStat_reg <= known(frame_reg[1]) ? `ASFI_ST_OK : `ASFI_ST_BADCMD;
      end
      if (frameEnd && csumOk) begin
        dirPend_reg <= 1'b1;
      end else if (frameEnd) begin
        replyOp_reg   <= frame_reg[1];
        replyStat_reg <= `ASFI_ST_CSUM;
      end
    end
  end

  // Parameter stores driven by the executor.
  // The data word samples the accumulator at every edge, so it carries the
  // execute-edge value only in the strobe cycle and follows later changes.
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      axisParamWr   <= 1'b0;
      globalParamWr <= 1'b0;
      userVarWr     <= 1'b0;
      paramNum      <= 8'h00;
      paramBank     <= 8'h00;
      paramData     <= `ASFI_ZERO32;
    end else begin
      axisParamWr   <= execGo && (exOp == `ASFI_OP_AXSTORE);
      globalParamWr <= execGo && (exOp == `ASFI_OP_GLSTORE) && (exBank != `ASFI_BANK_USER);
      userVarWr     <= execGo && (exOp == `ASFI_OP_GLSTORE) && (exBank == `ASFI_BANK_USER);
      paramNum      <= exType;
      paramBank     <= exBank;
      paramData     <= curAcc;
    end
  end

  // Error flags: a source setting a flag wins over a clear in the same cycle.
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      errFlags <= 5'h00;
    end else if (execGo && (exOp == `ASFI_OP_CLE)) begin
      errFlags <= (errFlags & ~cleMask(exType)) | errSet;
    end else begin
      errFlags <= errFlags | errSet;
    end
  end

  // Interrupt enables; numbers beyond the source list are ignored.
  // Numbers 16 to 254 therefore change nothing, which keeps unknown sources off.
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      irqEnable   <= 16'h0000;
      irqGlobalEn <= 1'b0;
    end else if (execGo && (exOp == `ASFI_OP_IRQON)) begin
      if (exType == `ASFI_IRQ_GLOBAL) begin
        irqGlobalEn <= 1'b1;
      end else if (exType < `ASFI_NIRQ) begin
        irqEnable[exType[3:0]] <= 1'b1;
      end
    end else if (execGo && (exOp == `ASFI_OP_IRQOFF)) begin
      if (exType == `ASFI_IRQ_GLOBAL) begin
        irqGlobalEn <= 1'b0;
      end else if (exType < `ASFI_NIRQ) begin
        irqEnable[exType[3:0]] <= 1'b0;
      end
    end
  end

  // Vector table: each entry simply takes the newest label written to it.
  genvar g;
  generate
    for (g = 0; g < `ASFI_NIRQ; g = g + 1) begin : gVec
      always @(posedge sys_clk) begin
        if (!rst_b) begin
          vec_reg[g] <= 24'h00_0000;
        end else if (execGo && (exOp == `ASFI_OP_SETVEC) && (exType == g)) begin
          vec_reg[g] <= exValue[23:0];
        end
      end
    end
  endgenerate

  // Registered vector lookup for the sequencer's interrupt dispatch.
  // The lookup costs one cycle; the sequencer must wait for it before jumping.
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      vecAddr <= 24'h00_0000;
    end else begin
      vecAddr <= vec_reg[vecIdx];
    end
  end

  // Context save on entry, restore on return; handlers must end in a return.
  // A return without a prior entry hands back the reset context.
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      svAcc_reg   <= `ASFI_ZERO32;
      svX_reg     <= `ASFI_ZERO32;
      svFlags_reg <= 8'h00;
      svPc_reg    <= 24'h00_0000;
      ctxRestore  <= 1'b0;
      rstAcc      <= `ASFI_ZERO32;
      rstX        <= `ASFI_ZERO32;
      rstFlags    <= 8'h00;
      rstPc       <= 24'h00_0000;
    end else begin
      if (irqEntry) begin
        svAcc_reg   <= curAcc;
        svX_reg     <= curX;
        svFlags_reg <= curFlags;
        svPc_reg    <= curPc;
      end
      ctxRestore <= execGo && (exOp == `ASFI_OP_IRQRET);
      rstAcc     <= svAcc_reg;
      rstX       <= svX_reg;
      rstFlags   <= svFlags_reg;
      rstPc      <= svPc_reg;
    end
  end

  // Sticky events cleared by reading them; a new event beats the clear.
  // The interrupt line lags the event register by one cycle to stay registered.
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      evt_reg  <= {`ASFI_EVT_W{1'b0}};
      mask_reg <= {`ASFI_EVT_W{1'b0}};
      irqOut   <= 1'b0;
    end else begin
      if (apbRd && (paddr == `ASFI_A_EVT)) begin
        evt_reg <= evtSet;
      end else begin
        evt_reg <= evt_reg | evtSet;
      end
      if (apbWr && (paddr == `ASFI_A_MASK)) begin
        mask_reg <= pwdata[`ASFI_EVT_W-1:0];
      end
      irqOut <= |(evt_reg & mask_reg);
    end
  end

endmodule
`default_nettype wire

// >>> tb/asfi_cmd_monitor.sv
// Checker for program-path stores, enables, flag clears and restores.
// Assumes binding to asfi_cmd_exec: one clock, synchronous low reset.
`timescale 1ns/1ps
`default_nettype none
module asfi_cmd_monitor (
  // Clock and reset.
  input wire logic        sys_clk,
  input wire logic        rst_b,
  // Program instruction and state.
  input wire logic        progValid,
  input wire logic [7:0]  progOp,
  input wire logic [7:0]  progType,
  input wire logic [7:0]  progBank,
  input wire logic [31:0] curAcc,
  input wire logic [4:0]  errSet,
  // Watched outputs.
  input wire logic        axisParamWr,
  input wire logic        globalParamWr,
  input wire logic        userVarWr,
  input wire logic [7:0]  paramNum,
  input wire logic [31:0] paramData,
  input wire logic [15:0] irqEnable,
  input wire logic        irqGlobalEn,
  input wire logic [4:0]  errFlags,
  input wire logic        ctxRestore
);
  // One clock domain, so clock and reset are given once.
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  axis_store_a: assert property (
    progValid && progOp == 8'h22 |=> axisParamWr && paramData == $past(curAcc))
    else $error("axis store missing");
  global_store_a: assert property (
    progValid && progOp == 8'h23 && progBank != 8'h02 |=> globalParamWr && paramNum == $past(progType))
    else $error("global store missing");
  user_var_a: assert property (
    progValid && progOp == 8'h23 && progBank == 8'h02 |=> userVarWr && !globalParamWr)
    else $error("user variable store missing");
  one_strobe_a: assert property ($onehot0({axisParamWr, globalParamWr, userVarWr}))
    else $error("several store strobes");
  src_enable_a: assert property (
    progValid && progOp == 8'h19 && progType < 8'h10 |=> irqEnable[$past(progType[3:0])])
    else $error("source enable not set");
  global_on_a: assert property (progValid && progOp == 8'h19 && progType == 8'hFF |=> irqGlobalEn)
    else $error("global enable not set");
  src_disable_a: assert property (
    progValid && progOp == 8'h1A && progType < 8'h10 |=> !irqEnable[$past(progType[3:0])])
    else $error("source enable not cleared");
  global_off_a: assert property (progValid && progOp == 8'h1A && progType == 8'hFF |=> !irqGlobalEn)
    else $error("global enable not cleared");
  flags_all_a: assert property (
    progValid && progOp == 8'h24 && progType == 8'h00 && errSet == 5'h00 |=> errFlags == 5'h00)
    else $error("flags not all cleared");
  ctx_restore_a: assert property (progValid && progOp == 8'h26 |=> ctxRestore)
    else $error("restore pulse missing");
endmodule
bind asfi_cmd_exec asfi_cmd_monitor mon (.sys_clk(sys_clk), .rst_b(rst_b), .progValid(progValid),
  .progOp(progOp), .progType(progType), .progBank(progBank), .curAcc(curAcc), .errSet(errSet),
  .axisParamWr(axisParamWr), .globalParamWr(globalParamWr), .userVarWr(userVarWr),
  .paramNum(paramNum), .paramData(paramData), .irqEnable(irqEnable),
  .irqGlobalEn(irqGlobalEn), .errFlags(errFlags), .ctxRestore(ctxRestore));
`default_nettype wire

// >>> tb/asfi_host_model.sv
// Host model: APB master that sends nine-byte command frames.
// Assumes the block answers each transfer with pready at some later edge.
`timescale 1ns/1ps
`default_nettype none
module asfi_host_model (
  // Clock.
  input wire logic         sys_clk,
  // APB master side.
  output var logic         psel,
  output var logic         penable,
  output var logic         pwrite,
  output var logic [7:0]   paddr,
  output var logic [31:0]  pwdata,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr
);
  logic [31:0] rdData;
  logic        lastErr;
  // Idle bus at time zero.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // One transfer; request held until pready is seen at an edge.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // No cycle limit here: only the bench timeout ends a wait.
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rdData = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines flip so stale values never look valid.
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  // Value goes most significant first; bad flips bit 0 of the checksum.
  task automatic send_frame(input logic [7:0] op, input logic [7:0] ty, input logic [7:0] bk,
                            input logic [31:0] v, input logic bad);
    logic [7:0] b [0:7];
    logic [7:0] sum;
    b = '{8'h01, op, ty, bk, v[31:24], v[23:16], v[15:8], v[7:0]};
    sum = 8'h00;
    foreach (b[i]) begin
      xfer(1'b1, 8'h00, {24'h00_0000, b[i]});
      sum = sum + b[i];
    end
    xfer(1'b1, 8'h00, {24'h00_0000, sum ^ {7'h00, bad}});
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Bench: table of program instructions, then flags, vectors, restore and frames.
// Assumes the host model drives APB and the checker is bound to the design.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {logic [7:0] op, ty, bk; logic [19:0] ex;} asfi_row_t;
  logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, progValid, irqEntry;
  logic axisParamWr, globalParamWr, userVarWr, irqGlobalEn, ctxRestore, irqOut;
  logic [7:0] paddr, progOp, progType, progBank, curFlags, paramNum, paramBank, rstFlags;
  logic [31:0] pwdata, prdata, progValue, curAcc, curX, paramData, rstAcc, rstX;
  logic [23:0] curPc, vecAddr, rstPc;
  logic [15:0] irqEnable;
  logic [4:0]  errSet, errFlags;
  logic [3:0]  vecIdx;
  int          nFail, cmpCount, cyc;
  asfi_row_t   rows [10] = '{'{8'h22, 8'h07, 8'h01, 20'h8_0000}, '{8'h23, 8'h05, 8'h00, 20'h4_0000},
    '{8'h23, 8'h2A, 8'h02, 20'h2_0000}, '{8'h19, 8'h03, 8'h00, 20'h0_0008},
    '{8'h19, 8'h0F, 8'h09, 20'h0_8008}, '{8'h19, 8'hFF, 8'h00, 20'h1_8008},
    '{8'h1A, 8'h03, 8'h00, 20'h1_8000}, '{8'h1A, 8'hFF, 8'h00, 20'h0_8000},
    '{8'h19, 8'h10, 8'h00, 20'h0_8000}, '{8'h1A, 8'h0F, 8'h00, 20'h0_0000}};
  asfi_cmd_exec uut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .progValid(progValid), .progOp(progOp), .progType(progType),
    .progBank(progBank), .progValue(progValue), .curAcc(curAcc), .curX(curX),
    .curFlags(curFlags), .curPc(curPc), .irqEntry(irqEntry), .vecIdx(vecIdx),
    .vecAddr(vecAddr), .errSet(errSet), .errFlags(errFlags), .axisParamWr(axisParamWr),
    .globalParamWr(globalParamWr), .userVarWr(userVarWr), .paramNum(paramNum),
    .paramBank(paramBank), .paramData(paramData), .irqEnable(irqEnable),
    .irqGlobalEn(irqGlobalEn), .ctxRestore(ctxRestore), .rstAcc(rstAcc), .rstX(rstX),
    .rstFlags(rstFlags), .rstPc(rstPc), .irqOut(irqOut));
  asfi_host_model host (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // Free-running clock at 4 ns.
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // A hang is counted as a mismatch; 5000 cycles is far past the expected run.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      nFail++;
      giveVerdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      nFail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Program instruction: executes at the next edge, outputs read just after it.
  task automatic prog(input logic [7:0] op, input logic [7:0] ty, input logic [7:0] bk,
                      input logic [31:0] v);
    @(posedge sys_clk);
    {progValid, progOp, progType, progBank, progValue} <= {1'b1, op, ty, bk, v};
    @(posedge sys_clk);
    progValid <= 1'b0;
    #1;
  endtask
  task automatic giveVerdict();
    $display("Counts: %0d compares, %0d mismatches", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Main sequence.
  initial begin
    {progValid, progOp, progType, progBank, progValue, irqEntry} = '0;
    {curAcc, curX, curFlags, curPc, errSet, vecIdx, rst_b} = '0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk) #1 check({irqEnable, irqGlobalEn, errFlags, pready, pslverr, irqOut, ctxRestore}, 32'h0000_0000);
    foreach (rows[i]) begin
      @(posedge sys_clk) curAcc <= 32'h1234_0000 + i;
      prog(rows[i].op, rows[i].ty, rows[i].bk, 32'hDEAD_BEEF);
      check({axisParamWr, globalParamWr, userVarWr, irqGlobalEn, irqEnable}, rows[i].ex);
      if (rows[i].ex[19:17] != 3'b000) begin
        check({paramNum, paramBank}, {rows[i].ty, rows[i].bk});
        check(paramData, curAcc);
      end
    end
    $display("Test done: instruction table");
    for (int k = 0; k <= 6; k++) begin
      @(posedge sys_clk) errSet <= 5'h1F;
      @(posedge sys_clk) errSet <= 5'h00;
      prog(8'h24, k[7:0], 8'h07, 32'hFFFF_FFFF);
      check(errFlags, k == 0 ? 5'h00 : k <= 5 ? 5'h1F & ~(5'h01 << (k - 1)) : 5'h1F);
    end
    $display("Test done: flag clears");
    @(posedge sys_clk) vecIdx <= 4'h3;
    // Vector commands stay on the program path, never sent as frames.
    prog(8'h25, 8'h03, 8'h00, 32'h0012_3456);
    @(posedge sys_clk) #1 check(vecAddr, 24'h12_3456);
    prog(8'h25, 8'h03, 8'h00, 32'h00AB_CDEF);
    @(posedge sys_clk) #1 check(vecAddr, 24'hAB_CDEF);
    @(posedge sys_clk) {irqEntry, curAcc, curX, curFlags, curPc} <=
      {1'b1, 32'hA5A5_0001, 32'h5A5A_0002, 8'h11, 24'h00_0077};
    @(posedge sys_clk) {irqEntry, curAcc, curX, curFlags, curPc} <=
      {1'b0, 32'h0000_0022, 32'h0000_0033, 8'h22, 24'h00_0099};
    prog(8'h26, 8'h00, 8'h00, 32'h0000_0000);
    check(ctxRestore, 1'b1);
    check({rstFlags, rstPc}, {8'h11, 24'h00_0077});
    check(rstAcc, 32'hA5A5_0001);
    check(rstX, 32'h5A5A_0002);
    $display("Test done: vectors and restore");
    host.xfer(1'b1, 8'h0C, 32'h0000_0001);
    host.send_frame(8'h22, 8'h05, 8'h01, 32'h0000_0000, 1'b0);
    #1 check({axisParamWr, paramNum, paramBank}, {1'b1, 8'h05, 8'h01});
    check(paramData, curAcc);
    host.xfer(1'b0, 8'h04, 32'h0000_0000);
    check(host.rdData, 32'h0000_2264);
    check(irqOut, 1'b1);
    host.xfer(1'b0, 8'h08, 32'h0000_0000);
    check(host.rdData, 32'h0000_0001);
    repeat (2) @(posedge sys_clk);
    #1 check(irqOut, 1'b0);
    host.send_frame(8'h19, 8'hFF, 8'h00, 32'h0000_0000, 1'b1);
    host.xfer(1'b0, 8'h04, 32'h0000_0000);
    check({irqOut, irqGlobalEn, host.rdData[7:0]}, 10'h001);
    host.xfer(1'b0, 8'h08, 32'h0000_0000);
    check(host.rdData, 32'h0000_0002);
    host.xfer(1'b0, 8'h20, 32'h0000_0000);
    check(host.lastErr, 1'b1);
    $display("Test done: direct frames");
    prog(8'h19, 8'hFF, 8'h00, 32'h0000_0000);
    check(irqGlobalEn, 1'b1);
    @(posedge sys_clk) rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 check({irqEnable, irqGlobalEn, errFlags, axisParamWr}, 32'h0000_0000);
    @(posedge sys_clk) rst_b <= 1'b1;
    @(posedge sys_clk) #1 check({irqGlobalEn, errFlags, pready, irqOut}, 32'h0000_0000);
    $display("Test done: mid-run reset");
    giveVerdict();
  end
endmodule
`default_nettype wire
